// ==== design/serial_flash_front_end.sv ====
`timescale 1ns/1ps
`include "flash_fe_cfg.svh"
// Contract
// - Accept SPI mode 0 and mode 3
// - Sample on rising, drive on falling edge
// - Dual reads use lines zero and one
// - Quad reads use all four data lines
// - Quad commands need quad enable set
// - Line three pauses only without quad enable
// - Line three resets when selected, no quad
// - Dedicated reset pin ignores quad enable
// - Pause stops only the serial link
// - Pause starts with clock low
// - Pause ends with clock low
// - Paused: outputs off, inputs ignored
// - Deselect during pause resets interface
// - Held reset low triggers reset cycle
// - Reset restores volatile bits to defaults
// - Decode pages, sectors, blocks up to top
module serial_flash_front_end (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      sclk,
   input  wire logic                      cs_n,
   input  wire logic                      dedicated_reset_n,
   input  wire logic                      data_line_zero_in,
   output logic                           data_line_zero_out,
   output logic                           data_line_zero_oe,
   input  wire logic                      data_line_one_in,
   output logic                           data_line_one_out,
   output logic                           data_line_one_oe,
   input  wire logic                      data_line_two_in,
   output logic                           data_line_two_out,
   output logic                           data_line_two_oe,
   input  wire logic                      data_line_three_in,
   output logic                           data_line_three_out,
   output logic                           data_line_three_oe,
   input  wire logic                      quad_enable_bit,
   input  wire logic                      pin_function_select,
   input  wire logic [7:0]                tx_byte,
   output logic                           tx_req,
   output logic                           cmd_valid,
   output logic [7:0]                     cmd_opcode,
   output logic                           addr_valid,
   output flash_fe_pkg::flash_addr_t      addr,
   output logic                           rx_valid,
   output logic [7:0]                     rx_byte,
   output logic                           paused,
   output logic                           hw_reset,
   output logic                           frame_active
);
   import flash_fe_pkg::*;

   fe_state_t s;
   fe_state_t next_s;

   function automatic cmd_t decode(input logic [7:0] op);
      cmd_t c;
      c = '0;
      c.addr_lanes = `LANES_1;
      c.data_lanes = `LANES_1;
      c.addr_bits  = `ADDR3_BITS;
      c.dummy      = `DUMMY_NONE;
      unique case (op)
         `OP_READ, `OP_READ4: begin
            c.is_read = 1'b1;
         end
         `OP_FAST, `OP_FAST4: begin
            c.is_read = 1'b1;
            c.dummy   = `DUMMY_FAST;
         end
         `OP_DUAL_OUT, `OP_DUAL_OUT4: begin
            c.is_read    = 1'b1;
            c.data_lanes = `LANES_2;
            c.dummy      = `DUMMY_FAST;
         end
         `OP_DUAL_IO, `OP_DUAL_IO4: begin
            c.is_read    = 1'b1;
            c.addr_lanes = `LANES_2;
            c.data_lanes = `LANES_2;
            c.dummy      = `DUMMY_DUAL_IO;
         end
         `OP_QUAD_OUT, `OP_QUAD_OUT4: begin
            c.is_read    = 1'b1;
            c.quad       = 1'b1;
            c.data_lanes = `LANES_4;
            c.dummy      = `DUMMY_FAST;
         end
         `OP_QUAD_IO, `OP_QUAD_IO4: begin
            c.is_read    = 1'b1;
            c.quad       = 1'b1;
            c.addr_lanes = `LANES_4;
            c.data_lanes = `LANES_4;
            c.dummy      = `DUMMY_QUAD_IO;
         end
         default: begin
            c.is_read = 1'b0;
         end
      endcase
      // The 4-byte address variants take a 32-bit address
      if (op == `OP_READ4 || op == `OP_FAST4 || op == `OP_DUAL_OUT4 ||
          op == `OP_DUAL_IO4 || op == `OP_QUAD_OUT4 || op == `OP_QUAD_IO4) begin
         c.addr_bits = `ADDR4_BITS;
      end
      return c;
   endfunction : decode

   logic        rise;
   logic        fall;
   logic        hold_en;
   logic        reset_low;
   logic        rst_hit;
   logic [7:0]  b;
   cmd_t        c;

   always_comb begin
      next_s = s;
      rise      = 1'b0;
      fall      = 1'b0;
      hold_en   = 1'b0;
      reset_low = 1'b0;
      rst_hit   = 1'b0;
      b         = 8'h00;
      c         = '0;
      // Two-flop synchronisers; logic reads the second stage, and sclk_q adds a third sclk stage for edge detection
      next_s.sclk_m = sclk;
      next_s.sclk_s = s.sclk_m;
      next_s.sclk_q = s.sclk_s;
      next_s.cs_m   = cs_n;
      next_s.cs_s   = s.cs_m;
      next_s.dres_m = dedicated_reset_n;
      next_s.dres_s = s.dres_m;
      next_s.din_m  = {data_line_three_in, data_line_two_in, data_line_one_in, data_line_zero_in};
      next_s.din_s  = s.din_m;
      next_s.cmd_valid  = 1'b0;
      next_s.addr_valid = 1'b0;
      next_s.rx_valid   = 1'b0;
      next_s.tx_req     = 1'b0;

      hold_en   = ~quad_enable_bit & ~pin_function_select;
      reset_low = (~quad_enable_bit & pin_function_select & ~s.din_s[3])
                | ~s.dres_s;
      // Count how long the reset level has been held
      if (reset_low) begin
         if (s.rcnt != `RST_CNT_W'(`RESET_LOW_CYCLES)) begin
            next_s.rcnt = s.rcnt + `RST_CNT_W'(1);
         end
      end else begin
         next_s.rcnt = '0;
      end
      rst_hit = reset_low && (s.rcnt == `RST_CNT_W'(`RESET_LOW_CYCLES));
      next_s.hw_reset = rst_hit;

      // Pause tracking; only the serial link stops, core work carries on
      if (s.cs_s || !hold_en) begin
         next_s.paused = 1'b0;
      end else if (!s.paused && !s.din_s[3] && !s.sclk_s) begin
         next_s.paused = 1'b1;
      end else if (s.paused && s.din_s[3] && !s.sclk_s) begin
         next_s.paused = 1'b0;
      end

      // Edges are found on our clock; both idle levels work the same way
      rise = s.sclk_s & ~s.sclk_q & ~s.paused;
      fall = ~s.sclk_s & s.sclk_q & ~s.paused;

      if (s.cs_s) begin
         next_s.phase        = ST_IDLE;
         next_s.frame_active = 1'b0;
         next_s.lines.oe     = 4'h0;
      end else begin
         next_s.frame_active = 1'b1;
         unique case (s.phase)
            ST_IDLE: begin
               next_s.phase  = ST_OPCODE;
               next_s.bitcnt = '0;
               next_s.sh     = '0;
            end
            ST_OPCODE: begin
               if (rise) begin
                  next_s.sh     = {s.sh[30:0], s.din_s[0]};
                  next_s.bitcnt = s.bitcnt + 6'd1;
                  if (s.bitcnt + 6'd1 == `BYTE_BITS) begin
                     b                = {s.sh[6:0], s.din_s[0]};
                     c                = decode(b);
                     next_s.cmd       = c;
                     next_s.opcode    = b;
                     next_s.cmd_valid = 1'b1;
                     next_s.bitcnt    = '0;
                     next_s.sh        = '0;
                     if (c.quad && !quad_enable_bit) begin
                        next_s.phase = ST_IGNORE;
                     end else if (c.is_read) begin
                        next_s.phase = ST_ADDR;
                     end else begin
                        next_s.phase = ST_DATA_IN;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  unique case (s.cmd.addr_lanes)
                     `LANES_2: next_s.sh = {s.sh[29:0], s.din_s[1:0]};
                     `LANES_4: next_s.sh = {s.sh[27:0], s.din_s};
                     default:  next_s.sh = {s.sh[30:0], s.din_s[0]};
                  endcase
                  next_s.bitcnt = s.bitcnt + {3'd0, s.cmd.addr_lanes};
                  if (s.bitcnt + {3'd0, s.cmd.addr_lanes} == s.cmd.addr_bits) begin
                     next_s.bitcnt      = '0;
                     next_s.addr_valid  = 1'b1;
                     next_s.addr.addr   = next_s.sh[`ADDR_MSB:0];
                     next_s.addr.page   = next_s.sh[`ADDR_MSB:`PAGE_LSB];
                     next_s.addr.sector = next_s.sh[`ADDR_MSB:`SECTOR_LSB];
                     next_s.addr.block  = next_s.sh[`ADDR_MSB:`BLOCK_LSB];
                     next_s.addr.beyond = |next_s.sh[31:`ADDR_W];
                     if (s.cmd.dummy == `DUMMY_NONE) begin
                        next_s.phase = ST_DATA_OUT;
                     end else begin
                        next_s.phase = ST_DUMMY;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  next_s.bitcnt = s.bitcnt + 6'd1;
                  if (s.bitcnt[3:0] + 4'd1 == s.cmd.dummy) begin
                     next_s.bitcnt = '0;
                     next_s.phase  = ST_DATA_OUT;
                  end
               end
            end
            ST_DATA_OUT: begin
               unique case (s.cmd.data_lanes)
                  `LANES_2: next_s.lines.oe = `OE_2;
                  `LANES_4: next_s.lines.oe = `OE_4;
                  default:  next_s.lines.oe = `OE_1;
               endcase
               if (fall) begin
                  b = s.tsh;
                  if (s.bitcnt == 6'd0) begin
                     b              = tx_byte;
                     next_s.tx_req  = 1'b1;
                     next_s.bitcnt  = `BYTE_BITS;
                  end
                  unique case (s.cmd.data_lanes)
                     `LANES_2: begin
                        next_s.lines.o[1:0] = b[7:6];
                        next_s.tsh          = {b[5:0], 2'b00};
                     end
                     `LANES_4: begin
                        next_s.lines.o = b[7:4];
                        next_s.tsh     = {b[3:0], 4'h0};
                     end
                     default: begin
                        next_s.lines.o[1] = b[7];
                        next_s.tsh        = {b[6:0], 1'b0};
                     end
                  endcase
                  next_s.bitcnt = (s.bitcnt == 6'd0 ? `BYTE_BITS : s.bitcnt)
                                - {3'd0, s.cmd.data_lanes};
               end
            end
            ST_DATA_IN: begin
               if (rise) begin
                  next_s.sh     = {s.sh[30:0], s.din_s[0]};
                  next_s.bitcnt = s.bitcnt + 6'd1;
                  if (s.bitcnt + 6'd1 == `BYTE_BITS) begin
                     next_s.rx_byte  = {s.sh[6:0], s.din_s[0]};
                     next_s.rx_valid = 1'b1;
                     next_s.bitcnt   = '0;
                  end
               end
            end
            ST_IGNORE: begin
               // Rejected command: sit out the rest of the frame
               next_s.lines.oe = 4'h0;
            end
         endcase
      end

      if (s.paused) begin
         next_s.lines.oe = 4'h0;
      end
      // Deselect while paused drops the phase, bit count and both shift registers
      if (s.paused && s.cs_s) begin
         next_s.phase  = ST_IDLE;
         next_s.bitcnt = '0;
         next_s.sh     = '0;
         next_s.tsh    = '0;
      end
      if (rst_hit) begin
         // Volatile interface state is cleared and the phase is parked in ST_IGNORE, not its power-on ST_IDLE
         next_s.phase    = ST_IGNORE;
         next_s.paused   = 1'b0;
         next_s.lines    = '0;
         next_s.bitcnt   = '0;
         next_s.sh       = '0;
         next_s.tsh      = '0;
         next_s.cmd      = '0;
         next_s.opcode   = '0;
         next_s.addr     = '0;
         next_s.rx_byte  = '0;
         next_s.cmd_valid  = 1'b0;
         next_s.addr_valid = 1'b0;
         next_s.rx_valid   = 1'b0;
         next_s.tx_req     = 1'b0;
      end
      if (rst) begin
         next_s        = '0;
         next_s.phase  = ST_IDLE;
         next_s.sclk_m = 1'b0;
         next_s.cs_m   = 1'b1;
         next_s.cs_s   = 1'b1;
         next_s.dres_m = 1'b1;
         next_s.dres_s = 1'b1;
         next_s.din_m  = 4'hf;
         next_s.din_s  = 4'hf;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign data_line_zero_out  = s.lines.o[0];
   assign data_line_zero_oe   = s.lines.oe[0];
   assign data_line_one_out   = s.lines.o[1];
   assign data_line_one_oe    = s.lines.oe[1];
   assign data_line_two_out   = s.lines.o[2];
   assign data_line_two_oe    = s.lines.oe[2];
   assign data_line_three_out = s.lines.o[3];
   assign data_line_three_oe  = s.lines.oe[3];
   assign tx_req              = s.tx_req;
   assign cmd_valid           = s.cmd_valid;
   assign cmd_opcode          = s.opcode;
   assign addr_valid          = s.addr_valid;
   assign addr                = s.addr;
   assign rx_valid            = s.rx_valid;
   assign rx_byte             = s.rx_byte;
   assign paused              = s.paused;
   assign hw_reset            = s.hw_reset;
   assign frame_active        = s.frame_active;
endmodule : serial_flash_front_end

// ==== design/flash_fe_cfg.svh ====
`ifndef FLASH_FE_CFG_SVH
`define FLASH_FE_CFG_SVH
`define CLK_PERIOD_PS    5000
`define RESET_LOW_MIN_NS 1000
`define RESET_LOW_CYCLES ((`RESET_LOW_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RST_CNT_W        12
`define BYTE_BITS        6'd8
`define ADDR3_BITS       6'd24
`define ADDR4_BITS       6'd32
`define ADDR_W           25
`define ADDR_MSB         24
`define PAGE_LSB         8
`define SECTOR_LSB       12
`define BLOCK_LSB        16
`define LANES_1          3'd1
`define LANES_2          3'd2
`define LANES_4          3'd4
`define OE_1             4'h2
`define OE_2             4'h3
`define OE_4             4'hf
`define DUMMY_NONE       4'd0
`define DUMMY_FAST       4'd8
`define DUMMY_DUAL_IO    4'd4
`define DUMMY_QUAD_IO    4'd6
`define OP_READ          8'h03
`define OP_READ4         8'h13
`define OP_FAST          8'h0b
`define OP_FAST4         8'h0c
`define OP_DUAL_OUT      8'h3b
`define OP_DUAL_OUT4     8'h3c
`define OP_DUAL_IO       8'hbb
`define OP_DUAL_IO4      8'hbc
`define OP_QUAD_OUT      8'h6b
`define OP_QUAD_OUT4     8'h6c
`define OP_QUAD_IO       8'heb
`define OP_QUAD_IO4      8'hec
`endif

// ==== design/flash_fe_pkg.sv ====
`include "flash_fe_cfg.svh"
package flash_fe_pkg;
   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_OPCODE   = 7'h02,
      ST_ADDR     = 7'h04,
      ST_DUMMY    = 7'h08,
      ST_DATA_OUT = 7'h10,
      ST_DATA_IN  = 7'h20,
      ST_IGNORE   = 7'h40
   } phase_t;
   typedef struct packed {
      logic       is_read;
      logic       quad;
      logic [2:0] addr_lanes;
      logic [2:0] data_lanes;
      logic [5:0] addr_bits;
      logic [3:0] dummy;
   } cmd_t;
   typedef struct packed {
      logic [`ADDR_MSB:0]             addr;
      logic [`ADDR_MSB-`PAGE_LSB:0]   page;
      logic [`ADDR_MSB-`SECTOR_LSB:0] sector;
      logic [`ADDR_MSB-`BLOCK_LSB:0]  block;
      logic                           beyond;
   } flash_addr_t;
   typedef struct packed {
      logic [3:0] o;
      logic [3:0] oe;
   } lines_t;
   typedef struct packed {
      logic                 sclk_m, sclk_s, sclk_q;
      logic                 cs_m, cs_s;
      logic                 dres_m, dres_s;
      logic [3:0]           din_m, din_s;
      phase_t               phase;
      cmd_t                 cmd;
      logic [5:0]           bitcnt;
      logic [31:0]          sh;
      logic [7:0]           tsh;
      logic [`RST_CNT_W-1:0] rcnt;
      logic                 paused;
      logic                 hw_reset;
      lines_t               lines;
      logic                 cmd_valid;
      logic [7:0]           opcode;
      logic                 addr_valid;
      flash_addr_t          addr;
      logic                 rx_valid;
      logic [7:0]           rx_byte;
      logic                 tx_req;
      logic                 frame_active;
   } fe_state_t;
endpackage : flash_fe_pkg

// ==== verification/flash_fe_checker.sv ====
`timescale 1ns/1ps
`include "flash_fe_cfg.svh"
module flash_fe_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic dedicated_reset_n,
   input wire logic data_line_one_out,
   input wire logic data_line_zero_oe,
   input wire logic data_line_one_oe,
   input wire logic data_line_two_oe,
   input wire logic data_line_three_oe,
   input wire logic data_line_three_in,
   input wire logic quad_enable_bit,
   input wire logic pin_function_select,
   input wire logic paused,
   input wire logic hw_reset,
   input wire logic frame_active
);
   logic [`RST_CNT_W-1:0] low_cnt;
   logic                  any_oe;
   logic                  src_low;
   assign any_oe = data_line_zero_oe | data_line_one_oe | data_line_two_oe | data_line_three_oe;
   assign src_low = !dedicated_reset_n || (!data_line_three_in && !quad_enable_bit && pin_function_select);
   // Counts raw pin low time; saturates so a long hold cannot wrap back under the minimum
   always_ff @(posedge clk) begin
      if (rst || !src_low)
         low_cnt <= '0;
      else if (low_cnt != '1)
         low_cnt <= low_cnt + 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   paused_quiet_a: assert property (paused ##1 paused |-> !any_oe)
      else $error("line driven while paused");
   deselect_quiet_a: assert property (cs_n [*5] |-> !any_oe)
      else $error("line driven while deselected");
   select_frame_a: assert property (!cs_n [*5] |-> frame_active)
      else $error("frame not active while selected");
   quad_gate_a: assert property (!quad_enable_bit |-> !(data_line_two_oe || data_line_three_oe))
      else $error("upper lines driven without quad enable");
   pause_mode_a: assert property ($rose(paused) |-> !quad_enable_bit && !pin_function_select)
      else $error("pause in wrong pin mode");
   pause_start_a: assert property ($rose(paused) |-> !$past(sclk, 3) && !$past(data_line_three_in, 3))
      else $error("pause began without clock low");
   pause_end_a: assert property ($fell(paused) && data_line_three_in |-> !$past(sclk, 3))
      else $error("pause ended with clock high");
   deselect_clears_a: assert property (paused && cs_n ##1 cs_n [*4] |-> !paused)
      else $error("pause kept after deselect");
   reset_min_a: assert property ($rose(hw_reset) |-> low_cnt >= `RESET_LOW_CYCLES)
      else $error("reset before minimum low time");
   reset_timely_a: assert property (low_cnt == `RESET_LOW_CYCLES + 8 |-> hw_reset)
      else $error("reset missing after minimum low time");
   falling_drive_a: assert property ($changed(data_line_one_out) && data_line_one_oe
      && $past(data_line_one_oe) |-> !$past(sclk, 2))
      else $error("output changed outside clock low phase");
endmodule : flash_fe_checker

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      host_o,
   output logic [3:0]      host_oe,
   input  wire logic [3:0] line_in
);
   localparam int HALF = 32;
   logic idle_hi;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      host_o = 4'h0;
      host_oe = 4'h0;
      idle_hi = 1'b0;
   end
   // Clock rests at the mode's idle level and only moves inside a frame
   task automatic begin_frame(input logic m3);
      idle_hi = m3;
      sclk = m3;
      #HALF;
      cs_n = 1'b0;
      #HALF;
   endtask : begin_frame
   task automatic end_frame();
      sclk = idle_hi;
      #HALF;
      cs_n = 1'b1;
      #HALF;
   endtask : end_frame
   // New data after each falling edge, held across the rising edge
   task automatic put(input logic [31:0] d, input int nb, input int ln);
      logic [3:0] m;
      m = 4'((1 << ln) - 1);
      for (int i = nb - ln; i >= 0; i -= ln) begin
         sclk = 1'b0;
         host_o = (host_o & ~m) | (4'(d >> i) & m);
         host_oe = host_oe | m;
         #HALF;
         sclk = 1'b1;
         #HALF;
      end
   endtask : put
   task automatic tick(input int n);
      host_oe = 4'h0;
      repeat (n) begin
         sclk = 1'b0;
         #HALF;
         sclk = 1'b1;
         #HALF;
      end
   endtask : tick
   task automatic get(input int nb, input int ln, output logic [7:0] v);
      logic [3:0] m;
      m = 4'((1 << ln) - 1);
      host_oe = 4'h0;
      v = 8'h0;
      for (int i = 0; i < nb; i += ln) begin
         sclk = 1'b0;
         #HALF;
         v = (ln == 1) ? {v[6:0], line_in[1]} : 8'((v << ln) | (line_in & m));
         sclk = 1'b1;
         #HALF;
      end
   endtask : get
   task automatic lo();
      sclk = 1'b0;
      #HALF;
   endtask : lo
   task automatic hi();
      sclk = 1'b1;
      #HALF;
   endtask : hi
   // Released means the pull-up wins, so pin3 never drives high actively
   task automatic pin3(input logic l);
      host_o[3] = l;
      host_oe[3] = ~l;
   endtask : pin3
endmodule : spi_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
   $display("wrong value at %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
   import flash_fe_pkg::*;
   typedef struct packed {
      logic [7:0]  op;
      logic        qe;
      logic        m3;
      logic [5:0]  ab;
      logic [2:0]  al;
      logic [3:0]  dm;
      logic [2:0]  dl;
      logic [31:0] a;
      logic [7:0]  d;
   } row_t;
   typedef struct packed {
      logic       qe;
      logic       pfs;
      logic       ded;
      logic [8:0] n;
      logic       hw;
   } rrow_t;
   logic        clk, rst, ded_reset_n, qe, pfs;
   logic [7:0]  tx_byte, cmd_opcode, rx_byte, v, w;
   logic        tx_req, cmd_valid, addr_valid, rx_valid, paused, hw_reset, frame_active;
   logic [3:0]  host_o, host_oe;
   wire         d0_o, d0_oe, d1_o, d1_oe, d2_o, d2_oe, d3_o, d3_oe;
   wire  [3:0]  dev_o = {d3_o, d2_o, d1_o, d0_o};
   wire  [3:0]  dev_oe = {d3_oe, d2_oe, d1_oe, d0_oe};
   logic        sclk, cs_n;
   wire  [3:0]  line;
   flash_addr_t addr;
   int          n_fail = 0;
   int          n_tests = 0;
   int          n_oe = 0, n_cmd = 0, n_adr = 0, n_rx = 0, n_txr = 0;
   row_t rows [14] = '{
      '{8'h03, 0, 0, 24, 1, 0, 1, 32'h0, 8'ha5}, '{8'h13, 0, 1, 32, 1, 0, 1, 32'h01ffffff, 8'h5a},
      '{8'h0b, 0, 1, 24, 1, 8, 1, 32'hfff0ff, 8'h81}, '{8'h0c, 0, 0, 32, 1, 8, 1, 32'h02000100, 8'h7e},
      '{8'h3b, 0, 0, 24, 1, 8, 2, 32'h012345, 8'hc3}, '{8'h3c, 0, 1, 32, 1, 8, 2, 32'h00abcdef, 8'h3c},
      '{8'hbb, 0, 1, 24, 2, 4, 2, 32'h00f000, 8'he1}, '{8'hbc, 0, 0, 32, 2, 4, 2, 32'h01000000, 8'h1e},
      '{8'h6b, 1, 0, 24, 1, 8, 4, 32'h000100, 8'h96}, '{8'h6c, 1, 1, 32, 1, 8, 4, 32'h00000fff, 8'h4b},
      '{8'heb, 1, 1, 24, 4, 6, 4, 32'hfff000, 8'h69}, '{8'hec, 1, 0, 32, 4, 6, 4, 32'hfe000000, 8'hd2},
      '{8'h6b, 0, 0, 24, 1, 8, 4, 32'h000100, 8'h96}, '{8'h02, 0, 0, 24, 1, 0, 0, 32'h0, 8'h5a}};
   rrow_t rr [5] = '{'{0, 1, 0, 100, 0}, '{0, 1, 0, 215, 1}, '{1, 1, 0, 215, 0}, '{1, 0, 1, 215, 1},
      '{0, 0, 0, 215, 0}};
   // Zero and one keep no pull, so a released line shows the inverse of its last value
   for (genvar i = 0; i < 4; i++) begin : g_wire
      assign line[i] = dev_oe[i] ? dev_o[i] : host_oe[i] ? host_o[i] : (i >= 2) ? 1'b1 : ~host_o[i];
   end
   spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .host_o(host_o), .host_oe(host_oe), .line_in(line));
   serial_flash_front_end u_serial_flash_front_end (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dedicated_reset_n(ded_reset_n),
      .data_line_zero_in(line[0]), .data_line_zero_out(d0_o), .data_line_zero_oe(d0_oe),
      .data_line_one_in(line[1]), .data_line_one_out(d1_o), .data_line_one_oe(d1_oe),
      .data_line_two_in(line[2]), .data_line_two_out(d2_o), .data_line_two_oe(d2_oe),
      .data_line_three_in(line[3]), .data_line_three_out(d3_o), .data_line_three_oe(d3_oe),
      .quad_enable_bit(qe), .pin_function_select(pfs), .tx_byte(tx_byte), .tx_req(tx_req),
      .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .addr_valid(addr_valid), .addr(addr),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .paused(paused), .hw_reset(hw_reset),
      .frame_active(frame_active));
   always #2.5 clk = ~clk;
   // Strobe counters let each row check how often every pulse fired
   always @(posedge clk) begin
      n_oe  <= n_oe + (|dev_oe);
      n_cmd <= n_cmd + cmd_valid;
      n_adr <= n_adr + addr_valid;
      n_rx  <= n_rx + rx_valid;
      n_txr <= n_txr + tx_req;
   end
   // Off the half-step grid, so a 32 ns link step never lands on a clock edge
   task automatic wclk(input int n);
      repeat (n) @(posedge clk);
      #1.25;
   endtask : wclk
   task automatic run_row(input row_t r);
      int   c [5];
      logic srv;
      wclk(1);
      qe = r.qe;
      tx_byte = r.d;
      srv = r.dl != 0 && (r.qe || r.dl != 4);
      c = '{n_oe, n_cmd, n_adr, n_rx, n_txr};
      u_host.begin_frame(r.m3);
      u_host.put(r.op, 8, 1);
      if (r.dl == 0) u_host.put(r.d, 8, 1);
      else begin
         u_host.put(r.a, r.ab, r.al);
         u_host.tick(r.dm);
         u_host.get(8, r.dl, v);
      end
      u_host.end_frame();
      wclk(8);
      `CHK(cmd_opcode, r.op)
      `CHK(n_cmd - c[1], 1)
      `CHK(n_adr - c[2], srv ? 1 : 0)
      `CHK(n_rx - c[3], r.dl == 0 ? 1 : 0)
      `CHK(n_txr - c[4], srv ? 2 - r.m3 : 0)
      if (r.dl == 0) `CHK(rx_byte, r.d)
      else if (!r.qe && r.dl == 4) `CHK(n_oe - c[0], 0)
      else begin
         `CHK(v, r.d)
         `CHK(addr.addr, r.a[24:0])
         `CHK(addr.page, r.a[24:8])
         `CHK(addr.sector, r.a[24:12])
         `CHK(addr.block, r.a[24:16])
         `CHK(addr.beyond, r.ab == 32 && r.a[31:25] != 0)
      end
   endtask : run_row
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ded_reset_n = 1'b1;
      qe = 1'b0;
      pfs = 1'b0;
      tx_byte = 8'h0;
      wclk(6);
      rst = 1'b0;
      wclk(2);
      `CHK(dev_oe, 4'h0)
      `CHK(paused, 1'b0)
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      // Clock edges during the pause must not move the byte on
      tx_byte = 8'hc6;
      u_host.begin_frame(1'b0);
      u_host.put(8'h03, 8, 1);
      u_host.put(32'h0, 24, 1);
      u_host.get(4, 1, v);
      u_host.lo();
      u_host.pin3(1'b0);
      wclk(10);
      `CHK(paused, 1'b1)
      `CHK(dev_oe, 4'h0)
      repeat (3) begin
         u_host.hi();
         u_host.lo();
      end
      u_host.pin3(1'b1);
      wclk(10);
      `CHK(paused, 1'b0)
      u_host.get(4, 1, w);
      `CHK({v[3:0], w[3:0]}, 8'hc6)
      u_host.lo();
      u_host.pin3(1'b0);
      wclk(10);
      u_host.end_frame();
      wclk(10);
      `CHK(paused, 1'b0)
      `CHK(frame_active, 1'b0)
      u_host.pin3(1'b1);
      wclk(1);
      qe = 1'b1;
      u_host.begin_frame(1'b0);
      u_host.pin3(1'b0);
      wclk(10);
      `CHK(paused, 1'b0)
      u_host.pin3(1'b1);
      u_host.end_frame();
      $display("pause tests done");
      foreach (rr[i]) begin
         wclk(1);
         qe = rr[i].qe;
         pfs = rr[i].pfs;
         if (rr[i].ded) ded_reset_n = 1'b0;
         else u_host.pin3(1'b0);
         wclk(rr[i].n);
         `CHK(hw_reset, rr[i].hw)
         if (rr[i].hw) `CHK(cmd_opcode, 8'h00)
         ded_reset_n = 1'b1;
         u_host.pin3(1'b1);
         wclk(10);
         `CHK(hw_reset, 1'b0)
         $display("reset case %0d done", i);
      end
      run_row(rows[0]);
      $display("reset recovery done");
      finish_test();
   end
   // Whole run needs well under 100 us of link traffic
   initial begin
      #300000;
      n_fail++;
      finish_test();
   end
endmodule : tb_top
bind serial_flash_front_end flash_fe_checker u_flash_fe_checker (
   .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .dedicated_reset_n(dedicated_reset_n),
   .data_line_one_out(data_line_one_out), .data_line_zero_oe(data_line_zero_oe),
   .data_line_one_oe(data_line_one_oe), .data_line_two_oe(data_line_two_oe),
   .data_line_three_oe(data_line_three_oe), .data_line_three_in(data_line_three_in),
   .quad_enable_bit(quad_enable_bit), .pin_function_select(pin_function_select),
   .paused(paused), .hw_reset(hw_reset), .frame_active(frame_active));
